// ---- hw/eee_port_pkg.sv ----
package eee_port_pkg;

  // indirect access byte registers
  localparam logic [7:0] ADDR_IND_CTRL = 8'h6E;
  localparam logic [7:0] ADDR_IND_OFS  = 8'h6F;
  localparam logic [7:0] ADDR_IND_DATA = 8'hA0;

  // indirect control field layout
  localparam int         CTRL_SEL_HI   = 7;
  localparam int         CTRL_SEL_LO   = 5;
  localparam int         CTRL_RD_BIT   = 4;
  localparam int         CTRL_PORT_HI  = 3;
  localparam logic [2:0] SEL_EEE       = 3'h1;
  localparam logic [3:0] PORT_FIRST    = 4'h1;
  localparam logic [3:0] PORT_LAST     = 4'h3;
  localparam int         NUM_PORTS     = 3;

  // per-port byte offsets
  localparam logic [7:0] OFS_NP_HI     = 8'h26;
  localparam logic [7:0] OFS_NP_LO     = 8'h27;
  localparam logic [7:0] OFS_CAP_HI    = 8'h28;
  localparam logic [7:0] OFS_CAP_LO    = 8'h29;
  localparam logic [7:0] OFS_WAKE_HI   = 8'h2A;
  localparam logic [7:0] OFS_WAKE_LO   = 8'h2B;

  // field positions and reset values
  localparam int         NP_COMPLY_BIT = 12;
  localparam int         NP_TOGGLE_BIT = 11;
  localparam int         CAP_PEER_LSB  = 9;
  localparam int         CAP_ADV_BIT   = 1;
  localparam logic       ADV_RST       = 1'b1;
  localparam logic [15:0] WAKE_CNT_RST = 16'h0000;

  // wake error threshold
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int WAKE_THR_NS_X10 = 205;  // 20.5 us in units of 0.1 us
  localparam int WAKE_THR_CYC    = (WAKE_THR_NS_X10 * 100000) / CLK_PERIOD_PS;

  typedef struct packed {
    logic        comply_ack_flag;
    logic        toggle;
    logic [10:0] code;
  } np_word_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : eee_port_pkg

// ---- hw/eee_port_status_regs.sv ----
// Function
// - Bit 12 reads received comply-acknowledge flag, read-only, reset 0.
// - Bit 11 toggle is inverse of previously exchanged codeword toggle.
// - First next page toggle starts as inverse of base codeword bit 11.
// - Bits 10:0 hold received 11-bit message code, read-only, reset 0.
// - Host writes offset; device moves selected byte through the data register.
// - Capability register: first offset bits 15:8, next offset bits 7:0.
// - Bits 14:9 report far side peer EEE support per PHY type.
// - Bit 1 writable local 100BASE-TX advert, reset 1; reserved bits zero.
// - Wake error counter adds one per wake exceeding threshold.
// - Wake threshold defaults to 20.5 us.
// - Reading wake counter low byte subtracts the count returned; reset value zero.
`timescale 1ns/1ps
module eee_port_status_regs
  import eee_port_pkg::*;
#(
  parameter int unsigned WAKE_THR_CYCLES = WAKE_THR_CYC
) (
  input  wire logic                 clk_i,                           // system clock
  input  wire logic                 sys_rst_i,                       // sync reset
  input  wire reg_req_t             reg_req_i,                       // byte register request
  output logic     [7:0]            reg_rdata_o,                     // read data, next cycle
  input  wire logic [NUM_PORTS-1:0] np_base_valid_i,                 // base codeword received
  input  wire logic [NUM_PORTS-1:0] np_base_toggle_i,                // base codeword bit 11
  input  wire logic [NUM_PORTS-1:0] np_page_valid_i,                 // next page received
  input  wire np_word_t             np_page_i [NUM_PORTS],           // received next page
  input  wire logic [5:0]           far_side_peer_cap_i [NUM_PORTS], // peer EEE abilities
  input  wire logic [NUM_PORTS-1:0] wake_active_i,                   // lpi to idle in progress
  output logic     [NUM_PORTS-1:0]  local_adv_100tx_o                // local 100tx EEE advert
);

  logic [7:0]  ind_ctrl;
  logic [7:0]  ind_ofs;
  logic [7:0]  ind_data;
  np_word_t    np_rx     [NUM_PORTS];
  logic [5:0]  peer_cap  [NUM_PORTS];
  logic [15:0] wake_cnt  [NUM_PORTS];
  logic [15:0] wake_snap [NUM_PORTS];
  logic [15:0] wake_tmr  [NUM_PORTS];
  logic [NUM_PORTS-1:0] snap_valid;
  logic [NUM_PORTS-1:0] wake_hit;
  logic [NUM_PORTS-1:0] snap_take;
  logic [NUM_PORTS-1:0] cnt_clear;

  logic       ctrl_wr;
  logic       ofs_wr;
  logic       data_wr;
  logic       sel_ok;
  logic [1:0] port_idx;
  logic       fetch;
  logic       store;
  logic [7:0] fetch_byte;

  function automatic logic port_sel_ok(input logic [7:0] ctrl);
    port_sel_ok = (ctrl[CTRL_SEL_HI:CTRL_SEL_LO] == SEL_EEE)
               && (ctrl[CTRL_PORT_HI:0] >= PORT_FIRST)
               && (ctrl[CTRL_PORT_HI:0] <= PORT_LAST);
  endfunction : port_sel_ok

  assign ctrl_wr  = reg_req_i.wr && (reg_req_i.addr == ADDR_IND_CTRL);
  assign ofs_wr   = reg_req_i.wr && (reg_req_i.addr == ADDR_IND_OFS);
  assign data_wr  = reg_req_i.wr && (reg_req_i.addr == ADDR_IND_DATA);
  assign sel_ok   = port_sel_ok(ind_ctrl);
  assign port_idx = 2'(ind_ctrl[CTRL_PORT_HI:0] - PORT_FIRST);
  assign fetch    = ofs_wr && ind_ctrl[CTRL_RD_BIT] && sel_ok;
  assign store    = data_wr && !ind_ctrl[CTRL_RD_BIT] && sel_ok
                 && (ind_ofs == OFS_CAP_LO);

  // byte selected by the offset being written
  always_comb begin
    logic [15:0] np_word;
    logic [15:0] cap_word;
    np_word  = {3'h0, np_rx[port_idx]};
    cap_word = 16'h0000;
    cap_word[CAP_PEER_LSB +: 6] = peer_cap[port_idx];
    cap_word[CAP_ADV_BIT]       = local_adv_100tx_o[port_idx];
    case (reg_req_i.wdata)
      OFS_NP_HI:   fetch_byte = np_word[15:8];
      OFS_NP_LO:   fetch_byte = np_word[7:0];
      OFS_CAP_HI:  fetch_byte = cap_word[15:8];
      OFS_CAP_LO:  fetch_byte = cap_word[7:0];
      OFS_WAKE_HI: fetch_byte = wake_cnt[port_idx][15:8];
      OFS_WAKE_LO: fetch_byte = snap_valid[port_idx] ? wake_snap[port_idx][7:0]
                                                     : wake_cnt[port_idx][7:0];
      default:     fetch_byte = 8'h00;
    endcase
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      snap_take[p] = fetch && (port_idx == 2'(p)) && (reg_req_i.wdata == OFS_WAKE_HI);
      cnt_clear[p] = fetch && (port_idx == 2'(p)) && (reg_req_i.wdata == OFS_WAKE_LO);
      wake_hit[p]  = wake_active_i[p] && (wake_tmr[p] == 16'(WAKE_THR_CYCLES));
    end
  end

  // indirect control, offset and data byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ind_ctrl <= 8'h00;
      ind_ofs  <= 8'h00;
      ind_data <= 8'h00;
    end else begin
      if (ctrl_wr) ind_ctrl <= reg_req_i.wdata;
      if (ofs_wr)  ind_ofs  <= reg_req_i.wdata;
      if (fetch) begin
        ind_data <= fetch_byte;
      end else if (data_wr) begin
        ind_data <= reg_req_i.wdata;
      end
    end
  end

  // register read port
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ADDR_IND_CTRL: reg_rdata_o <= ind_ctrl;
        ADDR_IND_OFS:  reg_rdata_o <= ind_ofs;
        ADDR_IND_DATA: reg_rdata_o <= ind_data;
        default:       reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // received next page and peer capability
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst_i) begin
        np_rx[p]    <= '0;
        peer_cap[p] <= 6'h00;
      end else begin
        peer_cap[p] <= far_side_peer_cap_i[p];
        if (np_page_valid_i[p]) begin
          np_rx[p].comply_ack_flag <= np_page_i[p].comply_ack_flag;
          np_rx[p].toggle <= ~np_page_i[p].toggle;
          np_rx[p].code   <= np_page_i[p].code;
        end else if (np_base_valid_i[p]) begin
          np_rx[p].toggle <= ~np_base_toggle_i[p];
        end
      end
    end
  end

  // local advertisement
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst_i) begin
        local_adv_100tx_o[p] <= ADV_RST;
      end else if (store && (port_idx == 2'(p))) begin
        local_adv_100tx_o[p] <= reg_req_i.wdata[CAP_ADV_BIT];
      end
    end
  end

  // wake duration timer and error counter
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst_i) begin
        wake_tmr[p]   <= 16'h0000;
        wake_cnt[p]   <= WAKE_CNT_RST;
        wake_snap[p]  <= 16'h0000;
        snap_valid[p] <= 1'b0;
      end else begin
        if (!wake_active_i[p]) begin
          wake_tmr[p] <= 16'h0000;
        end else if (wake_tmr[p] != 16'hFFFF) begin
          wake_tmr[p] <= wake_tmr[p] + 16'h0001;
        end
        // a count arriving with the clear survives it
        wake_cnt[p] <= wake_cnt[p]
                     - (cnt_clear[p] ? (snap_valid[p] ? wake_snap[p] : wake_cnt[p])
                                     : 16'h0000)
                     + {15'h0000, wake_hit[p] && (wake_cnt[p] != 16'hFFFF)};
        if (snap_take[p]) begin
          wake_snap[p]  <= wake_cnt[p];
          snap_valid[p] <= 1'b1;
        end else if (cnt_clear[p]) begin
          snap_valid[p] <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_comply_ack;
    np_page_valid_i[0] |=> np_rx[0].comply_ack_flag == $past(np_page_i[0].comply_ack_flag);
  endproperty
  a_comply_ack: assert property (p_comply_ack) else $error("comply ack not captured");

  property p_toggle;
    np_page_valid_i[0] |=> np_rx[0].toggle != $past(np_page_i[0].toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not inverted");

  property p_toggle_init;
    np_base_valid_i[0] && !np_page_valid_i[0]
      |=> np_rx[0].toggle == !$past(np_base_toggle_i[0]);
  endproperty
  a_toggle_init: assert property (p_toggle_init) else $error("bad initial toggle");

  property p_code;
    np_page_valid_i[0] ##1 !np_page_valid_i[0] |-> np_rx[0].code == $past(np_page_i[0].code, 1);
  endproperty
  a_code: assert property (p_code) else $error("message code not held");

  property p_sel;
    ofs_wr && (ind_ctrl[CTRL_SEL_HI:CTRL_SEL_LO] != SEL_EEE) |=> $stable(ind_data);
  endproperty
  a_sel: assert property (p_sel) else $error("fetch without EEE select");

  property p_cap_hi;
    fetch && port_idx == 2'd0 && reg_req_i.wdata == OFS_CAP_HI
      |=> ind_data == {1'b0, $past(peer_cap[0]), 1'b0};
  endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("capability high byte wrong");

  property p_adv;
    store && port_idx == 2'd1
      |=> local_adv_100tx_o[1] == $past(reg_req_i.wdata[CAP_ADV_BIT]);
  endproperty
  a_adv: assert property (p_adv) else $error("advert bit not written");

  property p_wake_inc;
    wake_hit[2] && !cnt_clear[2] && wake_cnt[2] != 16'hFFFF
      |=> wake_cnt[2] == $past(wake_cnt[2]) + 16'h0001;
  endproperty
  a_wake_inc: assert property (p_wake_inc) else $error("wake error not counted");

  property p_wake_quiet;
    !wake_hit[2] && !cnt_clear[2] |=> $stable(wake_cnt[2]);
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("counter moved early");

  property p_clear;
    cnt_clear[2] && snap_valid[2] && !wake_hit[2]
      |=> wake_cnt[2] == $past(wake_cnt[2]) - $past(wake_snap[2]) && !snap_valid[2];
  endproperty
  a_clear: assert property (p_clear) else $error("read clear wrong");

endmodule : eee_port_status_regs

// ---- bench/eee_port_status_regs_tb.sv ----
`timescale 1ns/1ps
module eee_port_status_regs_tb;
  import eee_port_pkg::*;
  localparam int THR = 8;
  typedef struct packed {
    logic [3:0] port;
    logic [7:0] ofs;
    logic [7:0] exp;
  } row_t;
  logic                 clk_i, sys_rst_i;
  reg_req_t             req;
  logic [7:0]           rdata, got;
  logic [NUM_PORTS-1:0] base_v, base_t, page_v, wake, adv;
  np_word_t             page [NUM_PORTS];
  logic [5:0]           cap [NUM_PORTS];
  int                   num_errors, num_checks;
  row_t                 rows [12];

  eee_port_status_regs #(.WAKE_THR_CYCLES(THR)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .np_base_valid_i(base_v), .np_base_toggle_i(base_t), .np_page_valid_i(page_v),
    .np_page_i(page), .far_side_peer_cap_i(cap), .wake_active_i(wake),
    .local_adv_100tx_o(adv)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // inputs change 1 ns after the edge and hold until the next call
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    req = '{wr: w, rd: r, addr: a, wdata: d};
  endtask : bus

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    v = rdata;
  endtask : rd

  task automatic fetch(input logic [7:0] c, input logic [7:0] o, output logic [7:0] v);
    bus(1'b1, 1'b0, ADDR_IND_CTRL, c);
    bus(1'b1, 1'b0, ADDR_IND_OFS, o);
    rd(ADDR_IND_DATA, v);
  endtask : fetch

  task automatic put(input logic [7:0] c, input logic [7:0] o, input logic [7:0] d);
    bus(1'b1, 1'b0, ADDR_IND_CTRL, c);
    bus(1'b1, 1'b0, ADDR_IND_OFS, o);
    bus(1'b1, 1'b0, ADDR_IND_DATA, d);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : put

  task automatic wake_for(input int idx, input int n);
    @(posedge clk_i);
    #1;
    wake[idx] = 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
    wake[idx] = 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : wake_for

  initial begin
    req = '0;
    {base_v, base_t, page_v, wake} = '0;
    page = '{'{1'b1, 1'b0, 11'h5A5}, '{1'b0, 1'b1, 11'h7FF}, '{1'b1, 1'b1, 11'h001}};
    cap  = '{6'h2A, 6'h15, 6'h3F};
    rows = '{'{4'h1, 8'h26, 8'h1D}, '{4'h1, 8'h27, 8'hA5}, '{4'h1, 8'h28, 8'h54},
             '{4'h1, 8'h29, 8'h02}, '{4'h2, 8'h26, 8'h07}, '{4'h2, 8'h27, 8'hFF},
             '{4'h2, 8'h28, 8'h2A}, '{4'h2, 8'h29, 8'h02}, '{4'h3, 8'h26, 8'h10},
             '{4'h3, 8'h27, 8'h01}, '{4'h3, 8'h28, 8'h7E}, '{4'h3, 8'h29, 8'h02}};
    num_errors = 0;
    num_checks = 0;
    sys_rst_i  = 1'b1;
    repeat (10) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    check("rdata reset", rdata, 8'h00);
    check("advert reset", {5'h00, adv}, 8'h07);
    fetch(8'h31, OFS_NP_HI, got);
    check("page hi reset", got, 8'h00);
    fetch(8'h31, OFS_WAKE_LO, got);
    check("wake reset", got, 8'h00);
    // base codeword seeds toggle as its inverse
    @(posedge clk_i);
    #1;
    base_v = 3'b001;
    @(posedge clk_i);
    #1;
    base_v = 3'b000;
    fetch(8'h31, OFS_NP_HI, got);
    check("base toggle", got, 8'h08);
    @(posedge clk_i);
    #1;
    page_v = 3'b111;
    @(posedge clk_i);
    #1;
    page_v = 3'b000;
    foreach (rows[i]) begin
      fetch({SEL_EEE, 1'b1, rows[i].port}, rows[i].ofs, got);
      check("row byte", got, rows[i].exp);
    end
    fetch(8'h30, OFS_NP_HI, got);
    check("port zero refused", got, 8'h02);
    fetch(8'h51, OFS_NP_HI, got);
    check("selector refused", got, 8'h02);
    rd(8'h55, got);
    check("unmapped", got, 8'h00);
    put(8'h22, OFS_CAP_LO, 8'h00);
    check("advert cleared", {5'h00, adv}, 8'h05);
    fetch(8'h32, OFS_CAP_LO, got);
    check("advert readback", got, 8'h00);
    put(8'h42, OFS_CAP_LO, 8'h02);
    put(8'h22, OFS_CAP_HI, 8'h02);
    check("advert refused", {5'h00, adv}, 8'h05);
    put(8'h22, OFS_CAP_LO, 8'hFF);
    check("advert set", {5'h00, adv}, 8'h07);
    fetch(8'h32, OFS_CAP_LO, got);
    check("reserved zero", got, 8'h02);
    put(8'h21, OFS_NP_HI, 8'hFF);
    fetch(8'h31, OFS_NP_HI, got);
    check("page read only", got, 8'h1D);
    // short wake must not count, long ones count once each
    wake_for(2, 5);
    wake_for(2, 20);
    wake_for(2, 20);
    fetch(8'h33, OFS_WAKE_HI, got);
    check("wake hi", got, 8'h00);
    wake_for(2, 20);
    fetch(8'h33, OFS_WAKE_LO, got);
    check("wake lo", got, 8'h02);
    fetch(8'h33, OFS_WAKE_HI, got);
    fetch(8'h33, OFS_WAKE_LO, got);
    check("wake kept", got, 8'h01);
    fetch(8'h33, OFS_WAKE_HI, got);
    fetch(8'h33, OFS_WAKE_LO, got);
    check("wake cleared", got, 8'h00);
    fetch(8'h31, OFS_WAKE_LO, got);
    check("wake other port", got, 8'h00);
    tally_and_finish();
  end
endmodule : eee_port_status_regs_tb
